/* hw/pin_mux_defs.svh */
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFF_FUNC_SEL 16'h1C00
`define OFF_PUD_SER 16'h1C17
`define OFF_PUD_ADDR 16'h1C18
`define OFF_PUD_HD 16'h1C19
`define OFF_PUD_BE 16'h1C4F
`define OFF_PUD_CTL 16'h1C50

// ****************************************
// Field positions and reset values
// ****************************************
`define SEL_SP0_LSB 0
`define SEL_SP1_LSB 2
`define SEL_AMODE_LSB 4
`define SEL_PP_LSB 12
`define SEL_CLKS_BIT 15
`define SEL_RESET 16'h1000
`define PUD_RESET 16'h0000

// ****************************************
// Pin groups
// ****************************************
`define PIN_B 28
`define PIN_C 34
`define PIN_D 40
`define PIN_N 46

// ****************************************
// Function numbers, 0 means none
// ****************************************
`define FN_NONE 7'h00
`define FN_HOST 7'h01
`define FN_SPI 7'h1D
`define FN_GP 7'h24
`define FN_AUD2 7'h44
`define FN_UART 7'h48
`define FN_AUD3 7'h4C
`define FN_MEM 7'h50
`define FN_ADDR 7'h57
`define FN_CARD1 7'h5D
`define FN_MULTICHANNEL_SERIAL_PERIPHERAL 7'h63
`define FN_CARD0 7'h69
`define FN_AUD0 7'h6F
`define FN_BSP 7'h73
`define FN_N 122

`endif

/* hw/pin_mux_pkg.sv */
package pin_mux_pkg;

  typedef logic [6:0] fn_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [2:0] {
    PP_HOST = 3'h0,
    PP_SPI_AUD2 = 3'h1,
    PP_GPIO = 3'h2,
    PP_SPI_AUD3 = 3'h3,
    PP_AUD2_UART = 3'h4,
    PP_SPI_UART = 3'h5,
    PP_SPI_AUD2_AUD3 = 3'h6,
    PP_UNDEF = 3'h7
  } pp_mode_t;

endpackage

/* hw/serial_host_pin_mux.sv */
// Overview of operation
// - Every pin selection comes only from the function select register.
// - Three-bit parallel-port mode field picks host group functions, resets 001.
// - Mode 000 gives every host group pin to the host port.
// - Modes 001, 110 put SPI and general I/O 12-17 on first pins.
// - Host data 8-11: audio 2, general I/O, or SPI by mode.
// - Host data 12-15: UART, general I/O 28-31, or audio 3 by mode.
// - Memory strobes, masks, selects, clock enable own shared pins outside 000 and 111.
// - Serial port 1 mode: card port 1, multichannel SPI, general I/O 6-11.
// - Multichannel SPI pin order: clock, cs0, simo, somi, cs1, cs2.
// - Serial port 0 mode: card 0, audio 0, general I/O, buffered port.
// - Buffered port pin order: tx clock, tx sync, tx, rx, rx sync, clock.
// - Select bit 15 picks receive clock or sample-rate clock on sixth pin.
// - Each address mode bit picks address line or general I/O for its pin.
// - Pulldown register 1C17h bits 8-13 serve serial port 1 pins.
// - Same register bits 0-5 serve serial port 0 pins.
// - Register 1C18h bits 0-5 serve address lines 15 to 20.
// - 1C19h serves host data; 1C50h serves control, strobe, select pins.
// - 1C4Fh bits 7, 8 serve byte enable and data mask pins.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "pin_mux_defs.svh"

module serial_host_pin_mux
  import pin_mux_pkg::*;
(
  input wire logic CLK, // System clock
  input wire logic RST_B, // Async reset, active low
  input wire reg_req_t REQ, // Register request
  output logic [15:0] RDATA, // Read data, cycle after strobe
  input wire logic [`PIN_N-1:0] PIN_I, // Pin input levels
  output logic [`PIN_N-1:0] PIN_O, // Pin output levels
  output logic [`PIN_N-1:0] PIN_OE, // Pin output enables
  output logic [`PIN_N-1:0] PUD_INHIBIT, // Pulldown inhibit per pin
  input wire logic [`FN_N-1:0] FN_O, // Function outputs
  input wire logic [`FN_N-1:0] FN_OE, // Function output enables
  output logic [`FN_N-1:0] FN_I // Function inputs
);

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] sel_q;
  logic [15:0] pud_ser_q;
  logic [15:0] pud_addr_q;
  logic [15:0] pud_hd_q;
  logic [15:0] pud_be_q;
  logic [15:0] pud_ctl_q;

  wire hit_sel = REQ.addr == `OFF_FUNC_SEL;
  wire hit_ser = REQ.addr == `OFF_PUD_SER;
  wire hit_addr = REQ.addr == `OFF_PUD_ADDR;
  wire hit_hd = REQ.addr == `OFF_PUD_HD;
  wire hit_be = REQ.addr == `OFF_PUD_BE;
  wire hit_ctl = REQ.addr == `OFF_PUD_CTL;

  wire [15:0] rdata_d = !REQ.rd ? 16'h0000 :
                        hit_sel ? sel_q :
                        hit_ser ? pud_ser_q :
                        hit_addr ? pud_addr_q :
                        hit_hd ? pud_hd_q :
                        hit_be ? pud_be_q :
                        hit_ctl ? pud_ctl_q : 16'h0000;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_q <= `SEL_RESET;
      pud_ser_q <= `PUD_RESET;
      pud_addr_q <= `PUD_RESET;
      pud_hd_q <= `PUD_RESET;
      pud_be_q <= `PUD_RESET;
      pud_ctl_q <= `PUD_RESET;
      RDATA <= 16'h0000;
    end else begin
      if (REQ.wr && hit_sel) sel_q <= REQ.wdata;
      if (REQ.wr && hit_ser) pud_ser_q <= REQ.wdata;
      if (REQ.wr && hit_addr) pud_addr_q <= REQ.wdata;
      if (REQ.wr && hit_hd) pud_hd_q <= REQ.wdata;
      if (REQ.wr && hit_be) pud_be_q <= REQ.wdata;
      if (REQ.wr && hit_ctl) pud_ctl_q <= REQ.wdata;
      RDATA <= rdata_d;
    end
  end

  // ****************************************
  // Mode fields
  // ****************************************
  wire pp_mode_t pp = pp_mode_t'(sel_q[`SEL_PP_LSB +: 3]);
  wire [1:0] sp1 = sel_q[`SEL_SP1_LSB +: 2];
  wire [1:0] sp0 = sel_q[`SEL_SP0_LSB +: 2];
  wire [5:0] amode = sel_q[`SEL_AMODE_LSB +: 6];
  wire clks = sel_q[`SEL_CLKS_BIT];

  // Host group: pin 0 interrupt, 1-16 data, 17-20 control, 21-27 shared
  function automatic fn_t sel_a(input logic [4:0] p, input pp_mode_t m);
    fn_t f;
    logic [1:0] k9;
    logic [1:0] k13;
    logic spi_m;
    begin
      f = `FN_NONE;
      k9 = 2'(p - 5'h09);
      k13 = 2'(p - 5'h0D);
      spi_m = (m == PP_SPI_AUD2) || (m == PP_SPI_AUD2_AUD3);
      if (m == PP_HOST) begin
        f = `FN_HOST + 7'(p);
      end else if (m == PP_UNDEF) begin
        f = `FN_NONE;
      end else if (p >= 5'h15) begin
        f = `FN_MEM + 7'(p - 5'h15);
      end else if (p >= 5'h11) begin
        if (spi_m) f = `FN_SPI + 7'(p - 5'h0E);
      end else if (p >= 5'h0D) begin
        case (m)
          PP_SPI_AUD2, PP_AUD2_UART, PP_SPI_UART: begin
            f = `FN_UART + 7'(k13);
          end
          PP_GPIO: begin
            f = `FN_GP + 7'h1C + 7'(k13);
          end
          default: begin
            f = `FN_AUD3 + 7'(k13);
          end
        endcase
      end else if (p >= 5'h09) begin
        case (m)
          PP_GPIO: begin
            f = (k9 == 2'h3) ? `FN_GP + 7'h1B : `FN_GP + 7'h12 + 7'(k9);
          end
          PP_SPI_AUD3, PP_SPI_UART: begin
            case (k9)
              2'h0: f = `FN_SPI;
              2'h1: f = `FN_SPI + 7'h03;
              2'h2: f = `FN_SPI + 7'h01;
              default: f = `FN_SPI + 7'h02;
            endcase
          end
          default: begin
            f = `FN_AUD2 + 7'(k9);
          end
        endcase
      end else if (spi_m) begin
        f = (p <= 5'h02) ? `FN_SPI + 7'(p) : `FN_GP + 7'h09 + 7'(p);
      end
      sel_a = f;
    end
  endfunction

  // ****************************************
  // Per-pin selection
  // ****************************************
  fn_t pin_sel [`PIN_N];
  logic [`PIN_N-1:0] pin_o_d;
  logic [`PIN_N-1:0] pin_oe_d;

  for (genvar g = 0; g < `PIN_N; g++) begin : g_pin
    if (g < `PIN_B) begin : g_a
      assign pin_sel[g] = sel_a(5'(g), pp);
    end else if (g < `PIN_C) begin : g_b
      localparam fn_t I = fn_t'(g - `PIN_B);
      assign pin_sel[g] = (sp1 == 2'h0) ? `FN_CARD1 + I :
                          (sp1 == 2'h1) ? `FN_MULTICHANNEL_SERIAL_PERIPHERAL + I :
                          (sp1 == 2'h2) ? `FN_GP + 7'h06 + I :
                          `FN_NONE;
    end else if (g < `PIN_D) begin : g_c
      localparam fn_t I = fn_t'(g - `PIN_C);
      wire fn_t bsp = (I < 7'h05) ? `FN_BSP + I :
                      clks ? `FN_BSP + 7'h06 : `FN_BSP + 7'h05;
      assign pin_sel[g] = (sp0 == 2'h0) ? `FN_CARD0 + I :
                          (sp0 == 2'h1) ? ((I < 7'h04) ? `FN_AUD0 + I :
                                           `FN_GP + I) :
                          (sp0 == 2'h2) ? `FN_GP + I :
                          bsp;
    end else begin : g_d
      localparam fn_t I = fn_t'(g - `PIN_D);
      assign pin_sel[g] = amode[g - `PIN_D] ? `FN_GP + 7'h15 + I :
                          `FN_ADDR + I;
    end
    wire sel_live = pin_sel[g] != `FN_NONE;
    assign pin_o_d[g] = sel_live & FN_O[pin_sel[g]];
    assign pin_oe_d[g] = sel_live & FN_OE[pin_sel[g]];
  end

  // ****************************************
  // Function inputs from pins
  // ****************************************
  logic [`FN_N-1:0] fn_i_d;

  always_comb begin
    fn_i_d = '0;
    for (int p = 0; p < `PIN_N; p++) begin
      if (pin_sel[p] != `FN_NONE) fn_i_d[pin_sel[p]] = PIN_I[p];
    end
  end

  // ****************************************
  // Pulldown inhibit per pin
  // ****************************************
  wire [`PIN_N-1:0] pud_d = {
    pud_addr_q[5:0],
    pud_ser_q[5:0],
    pud_ser_q[13:8],
    pud_ctl_q[1], pud_ctl_q[5], pud_ctl_q[4],
    pud_ctl_q[2], pud_ctl_q[3],
    pud_be_q[8:7],
    pud_ctl_q[11:8],
    pud_hd_q[15:0],
    pud_ctl_q[12]
  };

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PIN_O <= '0;
      PIN_OE <= '0;
      PUD_INHIBIT <= '0;
      FN_I <= '0;
    end else begin
      PIN_O <= pin_o_d;
      PIN_OE <= pin_oe_d;
      PUD_INHIBIT <= pud_d;
      FN_I <= fn_i_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Outputs lag reset release by one edge
  logic chk_live_q;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      chk_live_q <= 1'b0;
    end else begin
      chk_live_q <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!chk_live_q);

  sequence s_pp_write(logic [2:0] m);
    REQ.wr && hit_sel && REQ.wdata[14:12] == m;
  endsequence

  a_sel_readback: assert property (
    s_pp_write(3'h0) ##1 (REQ.rd && hit_sel && !REQ.wr)
    |=> RDATA == $past(sel_q))
    else $error("select register readback wrong");

  a_host_route: assert property (
    s_pp_write(3'h0) ##1 1'b1
    |=> PIN_O[1] == $past(FN_O[2]) && PIN_OE[27] == $past(FN_OE[28]))
    else $error("host port not routed");

  a_spi_route: assert property (
    pp == PP_SPI_AUD2_AUD3 |=> PIN_O[0] == $past(FN_O[29]))
    else $error("spi clock not on first pin");

  a_gpio_route: assert property (
    pp == PP_GPIO |=> PIN_O[12] == $past(FN_O[63]))
    else $error("general io 27 not routed");

  a_audio3_route: assert property (
    pp == PP_SPI_AUD3 |=> PIN_OE[13] == $past(FN_OE[76]))
    else $error("audio port 3 not routed");

  a_mem_route: assert property (
    pp != PP_HOST && pp != PP_UNDEF |=> PIN_O[27] == $past(FN_O[86]))
    else $error("memory clock enable not routed");

  a_multichannel_serial_peripheral_order: assert property (
    sp1 == 2'h1 |=> PIN_O[29] == $past(FN_O[100]))
    else $error("multichannel spi order wrong");

  a_bsp_clock: assert property (
    sp0 == 2'h3 && clks |=> PIN_O[39] == $past(FN_O[121]))
    else $error("sample rate clock not selected");

  a_audio0_in: assert property (
    sp0 == 2'h1 |=> FN_I[111] == $past(PIN_I[34]))
    else $error("audio port 0 input not routed");

  a_addr_mode: assert property (
    amode[0] |=> PIN_O[40] == $past(FN_O[57]) && FN_I[87] == 1'b0)
    else $error("address mode bit ignored");

  a_pud_map: assert property (
    1'b1 |=> PUD_INHIBIT[28] == $past(pud_ser_q[8]))
    else $error("serial 1 pulldown map wrong");

  a_undef_off: assert property (
    pp == PP_UNDEF |=> PIN_OE[`PIN_B-1:0] == '0)
    else $error("mode 111 drives a pin");

  a_host_irq: assert property (
    pp == PP_HOST |=> PIN_O[0] == $past(FN_O[1]))
    else $error("host interrupt not routed");

  a_spi_gpio: assert property (
    pp == PP_SPI_AUD2 |=> PIN_O[3] == $past(FN_O[48]))
    else $error("general io 12 not routed");

  a_spi_select: assert property (
    pp == PP_SPI_AUD2 |=> PIN_OE[20] == $past(FN_OE[35]))
    else $error("spi chip select 3 not routed");

  a_audio2_in: assert property (
    pp == PP_AUD2_UART |=> FN_I[71] == $past(PIN_I[12]))
    else $error("audio port 2 input not routed");

  a_spi_alt_route: assert property (
    pp == PP_SPI_UART |=> PIN_O[10] == $past(FN_O[32]))
    else $error("spi chip select 0 not on host data 9");

  a_uart_route: assert property (
    pp == PP_SPI_UART |=> PIN_OE[16] == $past(FN_OE[75]))
    else $error("uart transmit not routed");

  a_host_strobe: assert property (
    pp == PP_HOST |=> FN_I[22] == $past(PIN_I[21]) && FN_I[80] == 1'b0)
    else $error("byte enable pin not given to host");

  a_card1_route: assert property (
    sp1 == 2'h0 |=> PIN_O[33] == $past(FN_O[98]))
    else $error("card port 1 not routed");

  a_sp1_gpio: assert property (
    sp1 == 2'h2 |=> FN_I[47] == $past(PIN_I[33]))
    else $error("general io 11 input not routed");

  a_sp1_reserved: assert property (
    sp1 == 2'h3 |=> PIN_OE[`PIN_C-1:`PIN_B] == '0)
    else $error("reserved serial 1 mode drives a pin");

  a_card0_route: assert property (
    sp0 == 2'h0 |=> PIN_OE[34] == $past(FN_OE[105]))
    else $error("card port 0 not routed");

  a_bsp_order: assert property (
    sp0 == 2'h3 |=> FN_I[118] == $past(PIN_I[37]))
    else $error("buffered port receive data misplaced");

  a_bsp_rclk: assert property (
    sp0 == 2'h3 && !clks |=> FN_I[120] == $past(PIN_I[39]))
    else $error("receive clock not selected");

  a_pud_ser0: assert property (
    1'b1 |=> PUD_INHIBIT[39:34] == $past(pud_ser_q[5:0]))
    else $error("serial 0 pulldown map wrong");

  a_pud_addr: assert property (
    1'b1 |=> PUD_INHIBIT[45:40] == $past(pud_addr_q[5:0]))
    else $error("address pulldown map wrong");

  a_pud_host: assert property (
    1'b1 |=> PUD_INHIBIT[16:1] == $past(pud_hd_q))
    else $error("host data pulldown map wrong");

  a_pud_mask: assert property (
    1'b1 |=> PUD_INHIBIT[22:21] == $past(pud_be_q[8:7]))
    else $error("byte enable pulldown map wrong");

endmodule

/* dv/periph_model.sv */
`timescale 1ns/1ps
`include "pin_mux_defs.svh"

module periph_model (
  input wire logic [1:0] pat, // Pattern select
  input wire logic periph_rst, // Peripheral reset
  output logic [`FN_N-1:0] fn_o, // Function outputs
  output logic [`FN_N-1:0] fn_oe, // Function enables
  output logic [`PIN_N-1:0] pin_i // Pin levels
);
  // ****************************************
  // Peripherals quiet while held in reset
  // ****************************************
  always_comb begin
    for (int i = 0; i < `FN_N; i++) begin
      fn_o[i] = !periph_rst && ((i * i + i * pat + pat) % 5 < 2);
      fn_oe[i] = !periph_rst && ((i * 3 + pat * i) % 7 > 1);
    end
    for (int p = 0; p < `PIN_N; p++) begin
      pin_i[p] = (p * p * 3 + p * pat * 5 + pat) % 11 < 5;
    end
  end
endmodule

/* dv/serial_host_pin_mux_tb.sv */
`timescale 1ns/1ps
`include "pin_mux_defs.svh"

module serial_host_pin_mux_tb
  import pin_mux_pkg::*;
;
  logic clk;
  logic rst_b;
  logic prst;
  logic [1:0] pat;
  reg_req_t req;
  logic [15:0] rdata;
  logic [15:0] sel_v;
  logic [`PIN_N-1:0] pin_i, pin_o, pin_oe, pud;
  logic [`FN_N-1:0] fn_o, fn_oe, fn_i;
  logic [15:0] pr [5];
  logic [15:0] off [5] = '{`OFF_PUD_SER, `OFF_PUD_ADDR, `OFF_PUD_HD,
    `OFF_PUD_BE, `OFF_PUD_CTL};
  int failures = 0;
  int checked = 0;
  int cyc = 0;

  serial_host_pin_mux dut_u (
    .CLK(clk), .RST_B(rst_b), .REQ(req), .RDATA(rdata), .PIN_I(pin_i),
    .PIN_O(pin_o), .PIN_OE(pin_oe), .PUD_INHIBIT(pud), .FN_O(fn_o),
    .FN_OE(fn_oe), .FN_I(fn_i)
  );
  periph_model model_u (.pat(pat), .periph_rst(prst), .fn_o(fn_o),
    .fn_oe(fn_oe), .pin_i(pin_i));

  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [127:0] e,
                     input logic [127:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic wr_rd(input logic [15:0] a, input logic [15:0] wd,
                       output logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic prst_pulse();
    @(posedge clk);
    prst <= 1'b1;
    @(posedge clk);
    prst <= 1'b0;
  endtask

  // ****************************************
  // Reference pin maps
  // ****************************************
  function automatic int efn(int p, logic [15:0] s);
    logic [2:0] m;
    m = s[14:12];
    if (p < 28) begin
      if (m == 3'h0) return p + 1;
      if (m == 3'h7) return 0;
      if (p >= 21) return p + 59;
      if (p >= 9 && p <= 12) case (m)
        3'h2: return p == 12 ? 63 : p + 45;
        3'h3, 3'h5: return p == 9 ? 29 : p == 10 ? 32 : p + 19;
        default: return p + 59;
      endcase
      if (p >= 13 && p <= 16) case (m)
        3'h2: return p + 51;
        3'h3, 3'h6: return p + 63;
        default: return p + 59;
      endcase
      if (m != 3'h1 && m != 3'h6) return 0;
      return p == 0 ? 29 : p < 3 ? p + 29 : p < 9 ? p + 45 : p + 15;
    end
    if (p < 34) case (s[3:2])
      2'h0: return p + 65;
      2'h1: return p + 71;
      2'h2: return p + 14;
      default: return 0;
    endcase
    if (p < 40) case (s[1:0])
      2'h0: return p + 71;
      2'h1: return p < 38 ? p + 77 : p + 2;
      2'h2: return p + 2;
      default: return p == 39 ? 120 + s[15] : p + 81;
    endcase
    return s[p - 36] ? p + 17 : p + 47;
  endfunction

  function automatic logic epud(int p);
    case (p)
      0: return pr[4][12];
      21, 22: return pr[3][p - 14];
      23: return pr[4][3];
      24: return pr[4][2];
      25, 26: return pr[4][p - 21];
      27: return pr[4][1];
      default: ;
    endcase
    if (p < 17) return pr[2][p - 1];
    if (p < 21) return pr[4][p - 9];
    if (p < 34) return pr[0][p - 20];
    if (p < 40) return pr[0][p - 34];
    return pr[1][p - 40];
  endfunction

  task automatic chk();
    logic [`PIN_N-1:0] eo, eoe;
    logic [`FN_N-1:0] ei;
    int f;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      pat <= k[1:0];
      repeat (2) @(posedge clk);
      #1;
      eo = '0;
      eoe = '0;
      ei = '0;
      for (int p = 0; p < `PIN_N; p++) begin
        f = efn(p, sel_v);
        if (f != 0) begin
          eo[p] = fn_o[f];
          eoe[p] = fn_oe[f];
          ei[f] = pin_i[p];
        end
      end
      cmp("pin_o", eo, pin_o);
      cmp("pin_oe", eoe, pin_oe);
      cmp("fn_i", ei, fn_i);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [15:0] d;
    rd(`OFF_FUNC_SEL, d);
    cmp("func_sel", 16'h1000, d);
    sel_v = 16'h1000;
    chk();
  endtask

  task automatic t_pud();
    logic [15:0] d;
    logic [`PIN_N-1:0] ep;
    for (int n = 0; n < 2; n++) begin
      for (int r = 0; r < 5; r++) begin
        pr[r] = (n == 0 ? 16'hC3A5 : 16'h36C9) ^ {4{r[3:0]}};
        wr(off[r], pr[r]);
      end
      for (int r = 0; r < 5; r++) begin
        rd(off[r], d);
        cmp("pud_reg", pr[r], d);
      end
      for (int p = 0; p < `PIN_N; p++) ep[p] = epud(p);
      cmp("pud_pins", ep, pud);
    end
    rd(16'h1C01, d);
    cmp("unmapped", 16'h0000, d);
  endtask

  task automatic t_pp();
    logic [15:0] d;
    for (int m = 0; m < 8; m++) begin
      sel_v = {1'b0, m[2:0], 12'h000};
      wr_rd(`OFF_FUNC_SEL, sel_v, d);
      cmp("func_sel", sel_v, d);
      prst_pulse();
      chk();
    end
  endtask

  task automatic t_sp();
    logic [15:0] d;
    for (int m = 0; m < 16; m++) begin
      sel_v = {m[2], 3'h6, 2'h3, m[1:0], m[3:0], m[3:2], m[1:0]};
      wr(`OFF_FUNC_SEL, sel_v);
      rd(`OFF_FUNC_SEL, d);
      cmp("func_sel", sel_v, d);
      prst_pulse();
      chk();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    req = '0;
    pat = 2'h0;
    prst = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_pud();
    t_pp();
    t_sp();
    finish_test();
  end
endmodule
